// file: rtl/cap_key_params.svh
/*
  Constants of the capacitive key scan controller: register offsets,
  field positions, reset values and timing counts.
  Assumes inclusion by the scan controller and its bench only.
*/
`ifndef CAP_KEY_PARAMS_SVH
`define CAP_KEY_PARAMS_SVH

// ==========================================================
// Register offsets (5-bit register index on the plain port)
`define OFS_CTRL_ZERO 5'h00
`define OFS_CAL_LO 5'h01
`define OFS_CAL_HI 5'h02
`define OFS_MUX_SEL 5'h03
`define OFS_CTRL_ONE 5'h04
`define OFS_PRESET 5'h08
`define OFS_COUNT 5'h10

// ==========================================================
// Field positions
`define C0_FLAG_BIT 7
`define C0_IRQ_BIT 6
`define C0_START_BIT 5
`define C0_SHARED_BIT 2
`define C1_TSS_BIT 7
`define C1_ROEN_BIT 5
`define C1_KOEN_BIT 4
`define C1_WR_MASK 8'hBF

// ==========================================================
// Reset values
`define RST_REG8 8'h00
`define RST_CNT16 16'h0000
`define RST_SLOT5 5'h00

// ==========================================================
// Timing counts
`define SYS_DIV_TOP 2'h3
`define TMR_TOP 8'hFF
`define SLOT_TOP 5'h1F

`endif

// file: rtl/cap_key_pkg.sv
/*
  Types of the capacitive key scan controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cap_key_pkg;

  // ==========================================================
  // Scan sequencing states
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h1,
    ST_RUN = 3'h2,
    ST_DONE = 3'h4
  } scan_state_t;

endpackage

// file: rtl/cap_key_scan.sv
/*
  Capacitive key scan controller: per-module key enables, oscillator
  run controls, 8+5 bit time slot counters, sense counters, shared
  start and the scan interrupt flag.
  Assumes oscillators and pads outside, with oscillator outputs
  arriving asynchronously, and a plain register port on sys_clk_in.
*/
`timescale 1ns/1ps
`include "cap_key_params.svh"

// Summary of operation
// - Slot clock select bit 7: 0 picks reference oscillator, 1 picks system clock/4.
// - Reference oscillator runs only while its enable bit 5 is set.
// - Key sense oscillators run only while their enable bit 4 is set.
// - Key enable bits 0..3 hand each key pin to touch sensing.
// - Bit 6 reads zero; all implemented bits reset to zero.
// - Keys grouped four per module, keys 1-4 in module 0 onward.
// - Each key has its own sense oscillator; modules are identical.
// - Fixed measurement period comes from dividing the slot clock.
// - Sense oscillator cycles counted in the period form the result.
// - End of the fixed period raises the scan interrupt request.
// - Shared slot select lets module 0 counter govern every module.
// - One shared start bit launches all modules together.
// - Start low clears sense, 16-bit and 5-bit counters, not 8-bit one.
// - Start rising edge switches all counters on in every module.
// - 5-bit slot overflow of module 0 (shared) or of all enabled modules stops all oscillators and counters.
// - The 8+5 bit slot counter runs from reference osc or clock/4.
// - Interrupt on module 0 or all enabled modules overflowing.
// - Start syncs oscillators; slot flag stays high until overflow.
// - Overflow sets interrupt flag; software may only clear it.
// - Shared select 0: own slot counters; 1: module 0 counter.
module cap_key_scan
  import cap_key_pkg::*;
#(
  parameter int N_MOD = 4
)
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [4:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [N_MOD*4-1:0] sense_osc_in,
  input wire logic [N_MOD-1:0] ref_osc_in,
  output logic [7:0] rd_data_out,
  output logic scan_irq_out,
  output logic [N_MOD-1:0] ref_osc_run_out,
  output logic [N_MOD*4-1:0] sense_osc_run_out,
  output logic [N_MOD*4-1:0] key_touch_sel_out
);

  // ==========================================================
  // Declarations
  logic [7:0] ctrl_one_ff [N_MOD];
  logic [7:0] nxt_ctrl_one [N_MOD];
  logic [7:0] preset_ff [N_MOD];
  logic [7:0] nxt_preset [N_MOD];
  logic [7:0] mux_sel_ff;
  logic [7:0] nxt_mux_sel;
  logic start_ff;
  logic nxt_start;
  logic start_d_ff;
  logic shared_ff;
  logic nxt_shared;
  logic irq_ff;
  logic nxt_irq;
  scan_state_t state_ff;
  scan_state_t nxt_state;
  logic [15:0] cal_ff;
  logic [15:0] nxt_cal;
  logic [1:0] div_ff;
  logic [1:0] nxt_div;
  logic [7:0] nxt_rd_data;
  logic [N_MOD-1:0] nxt_ref_run;
  logic [N_MOD*4-1:0] nxt_sense_run;
  logic [N_MOD*4-1:0] nxt_key_sel;
  logic start_rise;
  logic running;
  logic div_tick;
  logic sel_done;
  logic done_evt;
  logic [N_MOD-1:0] done_w;
  logic [N_MOD-1:0] active_w;
  wire [N_MOD-1:0][15:0] cnt_w;
  logic [1:0] mod_idx;

  assign mod_idx = addr_in[1:0];
  assign start_rise = start_ff & ~start_d_ff;
  assign running = (state_ff == ST_RUN);
  assign div_tick = (div_ff == `SYS_DIV_TOP);
  assign sel_done = shared_ff ? done_w[0] : &(done_w | ~active_w);
  assign done_evt = running & start_ff & sel_done;

  // ==========================================================
  // Register file
  always_comb
  begin
    nxt_ctrl_one = ctrl_one_ff;
    nxt_preset = preset_ff;
    nxt_mux_sel = mux_sel_ff;
    nxt_start = start_ff;
    nxt_shared = shared_ff;
    nxt_irq = irq_ff;
    if (wr_en_in)
    begin
      if (addr_in == `OFS_CTRL_ZERO)
      begin
        nxt_start = wr_data_in[`C0_START_BIT];
        nxt_shared = wr_data_in[`C0_SHARED_BIT];
        if (!wr_data_in[`C0_IRQ_BIT])
        begin
          nxt_irq = 1'b0;
        end
      end
      else if (addr_in == `OFS_MUX_SEL)
      begin
        nxt_mux_sel = wr_data_in;
      end
      else if (addr_in[4:2] == 3'(`OFS_CTRL_ONE >> 2) && 32'(mod_idx) < N_MOD)
      begin
        nxt_ctrl_one[mod_idx] = wr_data_in & `C1_WR_MASK;
      end
      else if (addr_in[4:2] == 3'(`OFS_PRESET >> 2) && 32'(mod_idx) < N_MOD)
      begin
        nxt_preset[mod_idx] = wr_data_in;
      end
    end
    if (done_evt)
    begin
      nxt_irq = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < N_MOD; i++)
      begin
        ctrl_one_ff[i] <= `RST_REG8;
        preset_ff[i] <= `RST_REG8;
      end
      mux_sel_ff <= `RST_REG8;
      start_ff <= 1'b0;
      shared_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
    else
    begin
      ctrl_one_ff <= nxt_ctrl_one;
      preset_ff <= nxt_preset;
      mux_sel_ff <= nxt_mux_sel;
      start_ff <= nxt_start;
      shared_ff <= nxt_shared;
      irq_ff <= nxt_irq;
    end
  end

  // ==========================================================
  // Scan sequencing
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cal = cal_ff;
    nxt_div = div_ff + 2'h1;
    unique case (state_ff)
      ST_IDLE:
      begin
        if (start_rise)
        begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (!start_ff)
        begin
          nxt_state = ST_IDLE;
        end
        else if (sel_done)
        begin
          nxt_state = ST_DONE;
        end
        else
        begin
          nxt_cal = cal_ff + 16'h0001;
        end
      end
      ST_DONE:
      begin
        if (!start_ff)
        begin
          nxt_state = ST_IDLE;
        end
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (!start_ff)
    begin
      nxt_cal = `RST_CNT16;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_ff <= ST_IDLE;
      start_d_ff <= 1'b0;
      cal_ff <= `RST_CNT16;
      div_ff <= 2'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      start_d_ff <= start_ff;
      cal_ff <= nxt_cal;
      div_ff <= nxt_div;
    end
  end

  // ==========================================================
  // Per-module oscillator sampling and counters
  for (genvar m = 0; m < N_MOD; m++)
  begin : g_mod
    logic [3:0] key_en;
    logic [1:0] sel;
    logic ref_s1_ff;
    logic ref_s2_ff;
    logic ref_s3_ff;
    logic [3:0] key_s1_ff;
    logic [3:0] key_s2_ff;
    logic [3:0] key_s3_ff;
    logic ref_edge;
    logic sense_edge;
    logic tick;
    logic [7:0] tmr_ff;
    logic [7:0] nxt_tmr;
    logic [4:0] slot_ff;
    logic [4:0] nxt_slot;
    logic done_ff;
    logic nxt_done;
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;

    assign key_en = ctrl_one_ff[m][3:0];
    assign sel = mux_sel_ff[2*m +: 2];
    assign ref_edge = ref_s2_ff & ~ref_s3_ff & ctrl_one_ff[m][`C1_ROEN_BIT];
    assign sense_edge = key_s2_ff[sel] & ~key_s3_ff[sel] & key_en[sel]
      & ctrl_one_ff[m][`C1_KOEN_BIT];
    assign tick = ctrl_one_ff[m][`C1_TSS_BIT] ? div_tick : ref_edge;
    assign done_w[m] = done_ff;
    assign active_w[m] = |key_en;
    assign cnt_w[m] = cnt_ff;

    always_comb
    begin
      nxt_tmr = tmr_ff;
      nxt_slot = slot_ff;
      nxt_done = done_ff;
      nxt_cnt = cnt_ff;
      if (!start_ff)
      begin
        nxt_slot = `RST_SLOT5;
        nxt_done = 1'b0;
        nxt_cnt = `RST_CNT16;
      end
      else if (start_rise)
      begin
        nxt_tmr = preset_ff[m];
      end
      else if (running && !done_ff)
      begin
        if (sense_edge)
        begin
          nxt_cnt = cnt_ff + 16'h0001;
        end
        if (tick)
        begin
          if (tmr_ff == `TMR_TOP)
          begin
            nxt_tmr = preset_ff[m];
            nxt_slot = slot_ff + 5'h01;
            if (slot_ff == `SLOT_TOP)
            begin
              nxt_done = 1'b1;
            end
          end
          else
          begin
            nxt_tmr = tmr_ff + 8'h01;
          end
        end
      end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
      if (!rst_n_in)
      begin
        ref_s1_ff <= 1'b0;
        ref_s2_ff <= 1'b0;
        ref_s3_ff <= 1'b0;
        key_s1_ff <= 4'h0;
        key_s2_ff <= 4'h0;
        key_s3_ff <= 4'h0;
        tmr_ff <= `RST_REG8;
        slot_ff <= `RST_SLOT5;
        done_ff <= 1'b0;
        cnt_ff <= `RST_CNT16;
      end
      else
      begin
        ref_s1_ff <= ref_osc_in[m];
        ref_s2_ff <= ref_s1_ff;
        ref_s3_ff <= ref_s2_ff;
        key_s1_ff <= sense_osc_in[4*m +: 4];
        key_s2_ff <= key_s1_ff;
        key_s3_ff <= key_s2_ff;
        tmr_ff <= nxt_tmr;
        slot_ff <= nxt_slot;
        done_ff <= nxt_done;
        cnt_ff <= nxt_cnt;
      end
    end

    assign nxt_ref_run[m] = running & ctrl_one_ff[m][`C1_ROEN_BIT];
    assign nxt_sense_run[4*m +: 4] = {4{running & ctrl_one_ff[m][`C1_KOEN_BIT]}} & key_en;
    assign nxt_key_sel[4*m +: 4] = key_en;
  end

  // ==========================================================
  // Read path
  always_comb
  begin
    nxt_rd_data = 8'h00;
    if (rd_en_in)
    begin
      if (addr_in == `OFS_CTRL_ZERO)
      begin
        nxt_rd_data[`C0_FLAG_BIT] = running;
        nxt_rd_data[`C0_IRQ_BIT] = irq_ff;
        nxt_rd_data[`C0_START_BIT] = start_ff;
        nxt_rd_data[`C0_SHARED_BIT] = shared_ff;
      end
      else if (addr_in == `OFS_CAL_LO)
      begin
        nxt_rd_data = cal_ff[7:0];
      end
      else if (addr_in == `OFS_CAL_HI)
      begin
        nxt_rd_data = cal_ff[15:8];
      end
      else if (addr_in == `OFS_MUX_SEL)
      begin
        nxt_rd_data = mux_sel_ff;
      end
      else if (addr_in[4:2] == 3'(`OFS_CTRL_ONE >> 2) && 32'(mod_idx) < N_MOD)
      begin
        nxt_rd_data = ctrl_one_ff[mod_idx];
      end
      else if (addr_in[4:2] == 3'(`OFS_PRESET >> 2) && 32'(mod_idx) < N_MOD)
      begin
        nxt_rd_data = preset_ff[mod_idx];
      end
      else if (addr_in[4] && 32'(addr_in[3:1]) < N_MOD)
      begin
        nxt_rd_data = addr_in[0] ? cnt_w[addr_in[3:1]][15:8] : cnt_w[addr_in[3:1]][7:0];
      end
    end
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rd_data_out <= 8'h00;
      scan_irq_out <= 1'b0;
      ref_osc_run_out <= '0;
      sense_osc_run_out <= '0;
      key_touch_sel_out <= '0;
    end
    else
    begin
      rd_data_out <= nxt_rd_data;
      scan_irq_out <= nxt_irq;
      ref_osc_run_out <= nxt_ref_run;
      sense_osc_run_out <= nxt_sense_run;
      key_touch_sel_out <= nxt_key_sel;
    end
  end

endmodule

// file: verification/cap_key_scan_monitor.sv
/*
  Port checker of the key scan controller.
  Assumes one clock and the register port described for the block.
*/
`timescale 1ns/1ps
module cap_key_scan_monitor
  import cap_key_pkg::*;
#(
  parameter int N_MOD = 4
)
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [4:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] rd_data_out,
  input wire logic scan_irq_out,
  input wire logic [N_MOD-1:0] ref_osc_run_out,
  input wire logic [N_MOD*4-1:0] sense_osc_run_out,
  input wire logic [N_MOD*4-1:0] key_touch_sel_out
);
  // ==========================================================
  // Port relations
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic c0_wr;
  logic idle_run;
  assign c0_wr = wr_en_in && addr_in == 5'h00;
  assign idle_run = ref_osc_run_out == '0 && sense_osc_run_out == '0;

  a_rd_idle_zero: assert property (!$past(rd_en_in) |-> rd_data_out == 8'h00)
    else $error("read data outside read slot");
  a_bit6_zero: assert property ($past(rd_en_in) && $past(addr_in[4:2]) == 3'h1 |-> !rd_data_out[6])
    else $error("bit 6 read as one");
  a_rd_irq_flag: assert property ($past(rd_en_in) && $past(addr_in) == 5'h00 |-> rd_data_out[6] == $past(scan_irq_out))
    else $error("flag read differs from irq");
  a_irq_sticky: assert property (scan_irq_out && !(c0_wr && !wr_data_in[6]) |=> scan_irq_out)
    else $error("irq dropped without clear");
  a_irq_no_set: assert property (!scan_irq_out && c0_wr && idle_run |=> !scan_irq_out)
    else $error("software set irq");
  a_key_sel: assert property (wr_en_in && addr_in == 5'h04 |-> ##2 key_touch_sel_out[3:0] == $past(wr_data_in[3:0], 2))
    else $error("key select not updated");
  a_sense_gate: assert property ((sense_osc_run_out & ~(key_touch_sel_out | $past(key_touch_sel_out))) == '0)
    else $error("sense osc runs on disabled key");
  a_irq_stop: assert property ($rose(scan_irq_out) |=> idle_run)
    else $error("oscillators run after overflow");
  a_stop_clear: assert property (c0_wr && !wr_data_in[5] |-> ##4 idle_run)
    else $error("oscillators run after stop");

  c_irq: cover property ($rose(scan_irq_out));
  c_all_ref: cover property (ref_osc_run_out == '1);
  c_sense: cover property (sense_osc_run_out != '0 && !scan_irq_out);
endmodule

bind cap_key_scan cap_key_scan_monitor #(.N_MOD(N_MOD)) mon_u (.sys_clk_in, .rst_n_in,
  .addr_in, .wr_data_in, .wr_en_in, .rd_en_in, .rd_data_out, .scan_irq_out,
  .ref_osc_run_out, .sense_osc_run_out, .key_touch_sel_out);

// file: verification/cap_pad_model.sv
/*
  Pad and oscillator stand-in: an oscillator toggles only while run.
  Assumes run enables from the scan controller.
*/
`timescale 1ns/1ps
module cap_pad_model
#(
  parameter int N_MOD = 4
)
(
  input wire logic [N_MOD*4-1:0] sense_run_in,
  input wire logic [N_MOD-1:0] ref_run_in,
  output logic [N_MOD*4-1:0] sense_osc_out,
  output logic [N_MOD-1:0] ref_osc_out
);
  logic s_tgl;
  logic r_tgl;
  initial
  begin
    s_tgl = 1'b0;
    forever #130 s_tgl = ~s_tgl;
  end
  initial
  begin
    r_tgl = 1'b0;
    forever #270 r_tgl = ~r_tgl;
  end
  // A stopped oscillator is held low
  assign sense_osc_out = sense_run_in & {(N_MOD*4){s_tgl}};
  assign ref_osc_out = ref_run_in & {N_MOD{r_tgl}};
endmodule

// file: verification/test_cap_key_scan.sv
/*
  Bench of the key scan controller: register tasks and scan scenarios.
  Assumes the pad model and the bound port checker.
*/
`timescale 1ns/1ps
module test_cap_key_scan;
  import cap_key_pkg::*;
  logic sys_clk_in, rst_n_in, wr_en_in, rd_en_in, scan_irq_out;
  logic [4:0] addr_in;
  logic [7:0] wr_data_in, rd_data_out, d;
  logic [3:0] ref_osc_in, ref_osc_run_out;
  logic [15:0] sense_osc_in, sense_osc_run_out, key_touch_sel_out, w;
  int fails, tests_run, cyc, t0;

  cap_key_scan #(.N_MOD(4)) dut_u (.sys_clk_in, .rst_n_in, .addr_in, .wr_data_in,
    .wr_en_in, .rd_en_in, .sense_osc_in, .ref_osc_in, .rd_data_out, .scan_irq_out,
    .ref_osc_run_out, .sense_osc_run_out, .key_touch_sel_out);
  cap_pad_model #(.N_MOD(4)) pad_u (.sense_run_in(sense_osc_run_out),
    .ref_run_in(ref_osc_run_out), .sense_osc_out(sense_osc_in), .ref_osc_out(ref_osc_in));

  // ==========================================================
  // Clock, timeout and port tasks
  initial
  begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      fails++;
      test_done();
    end
  end
  task clk(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge sys_clk_in);
    addr_in <= a;
    wr_data_in <= v;
    wr_en_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_en_in <= 1'b0;
  endtask
  task rd(input logic [4:0] a);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_en_in <= 1'b0;
    #1 d = rd_data_out;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task rc(input logic [4:0] a, input logic [7:0] e);
    rd(a);
    chk({8'h00, d}, {8'h00, e});
  endtask
  task wirq(input int lim);
    for (int n = 0; n < lim && scan_irq_out !== 1'b1; n++)
      clk(1);
  endtask
  task test_done();
    $display("compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task t_reset();
    for (int m = 0; m < 4; m++)
    begin
      rc(5'h04 + 5'(m), 8'h00);
      rc(5'h08 + 5'(m), 8'h00);
    end
    rc(5'h00, 8'h00);
    chk(key_touch_sel_out, 16'h0000);
    $display("t_reset end");
  endtask
  task t_ctrl_one();
    for (int m = 0; m < 4; m++)
      wr(5'h04 + 5'(m), 8'hF0 | (8'h01 << m));
    for (int m = 0; m < 4; m++)
      rc(5'h04 + 5'(m), 8'hB0 | (8'h01 << m));
    chk(key_touch_sel_out, 16'h8421);
    rc(5'h1C, 8'h00);
    wr(5'h00, 8'h40);
    clk(1);
    chk({15'h0, scan_irq_out}, 16'h0000);
    $display("t_ctrl_one end");
  endtask
  task t_scan();
    for (int m = 0; m < 4; m++)
    begin
      wr(5'h04 + 5'(m), 8'hBF);
      wr(5'h08 + 5'(m), 8'hFF);
    end
    wr(5'h03, 8'h00);
    wr(5'h00, 8'h20);
    t0 = cyc;
    clk(4);
    chk({12'h000, ref_osc_run_out}, 16'h000F);
    chk(sense_osc_run_out, 16'hFFFF);
    rc(5'h00, 8'hA0);
    wirq(400);
    chk(16'(cyc - t0 >= 126 && cyc - t0 <= 140), 16'h0001);
    clk(2);
    chk(sense_osc_run_out | {12'h000, ref_osc_run_out}, 16'h0000);
    rd(5'h10);
    w[7:0] = d;
    rd(5'h11);
    w[15:8] = d;
    chk(16'(w >= 16'h002C && w <= 16'h0036), 16'h0001);
    clk(20);
    rc(5'h10, w[7:0]);
    wr(5'h00, 8'h20);
    clk(1);
    chk({15'h0, scan_irq_out}, 16'h0000);
    wr(5'h00, 8'h00);
    clk(1);
    rc(5'h10, 8'h00);
    rc(5'h01, 8'h00);
    rc(5'h08, 8'hFF);
    $display("t_scan end");
  endtask
  task t_shared();
    wr(5'h04, 8'hB1);
    for (int m = 1; m < 4; m++)
      wr(5'h04 + 5'(m), 8'h11);
    wr(5'h00, 8'h20);
    clk(4);
    chk({12'h000, ref_osc_run_out}, 16'h0001);
    chk(sense_osc_run_out, 16'h1111);
    wirq(400);
    chk({15'h0, scan_irq_out}, 16'h0000);
    wr(5'h00, 8'h00);
    clk(4);
    wr(5'h00, 8'h24);
    wirq(300);
    chk({15'h0, scan_irq_out}, 16'h0001);
    clk(2);
    chk(sense_osc_run_out | {12'h000, ref_osc_run_out}, 16'h0000);
    wr(5'h00, 8'h00);
    // Module 0 on its reference oscillator, muxed to a disabled key
    wr(5'h04, 8'h33);
    wr(5'h03, 8'h02);
    wr(5'h00, 8'h24);
    t0 = cyc;
    wirq(400);
    chk(16'(cyc - t0 >= 160 && cyc - t0 <= 190), 16'h0001);
    rc(5'h10, 8'h00);
    rc(5'h11, 8'h00);
    rd(5'h12);
    w[7:0] = d;
    rd(5'h13);
    w[15:8] = d;
    chk(16'(w >= 16'h003A && w <= 16'h004A), 16'h0001);
    wr(5'h00, 8'h00);
    $display("t_shared end");
  endtask

  initial
  begin
    rst_n_in = 1'b0;
    addr_in = 5'h00;
    wr_data_in = 8'h00;
    wr_en_in = 1'b0;
    rd_en_in = 1'b0;
    repeat (2) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_ctrl_one();
    t_scan();
    t_shared();
    test_done();
  end
endmodule
